// File: include/vsdma_pkg.sv
// Package for the video/scan address register block.
// Assumes a 32-bit AXI4-Lite slave, one 16-bit register per word.
package vsdma_pkg;
  // Printed register indices; the byte address is four times the index
  localparam logic [31:0] SAH1_IDX  = 32'h01FF828C;
  localparam logic [31:0] SAL1_IDX  = 32'h01FF828E;
  localparam logic [31:0] SAH2_IDX  = 32'h01FF8290;
  localparam logic [31:0] SAL2_IDX  = 32'h01FF8292;
  localparam logic [31:0] STPH_IDX  = 32'h01FF8294;
  localparam logic [31:0] STPL_IDX  = 32'h01FF8296;
  localparam logic [31:0] MODE_IDX  = 32'h01FF8298;
  localparam logic [31:0] SAH1_ADDR = {SAH1_IDX[29:0], 2'b00};
  localparam logic [31:0] SAL1_ADDR = {SAL1_IDX[29:0], 2'b00};
  localparam logic [31:0] SAH2_ADDR = {SAH2_IDX[29:0], 2'b00};
  localparam logic [31:0] SAL2_ADDR = {SAL2_IDX[29:0], 2'b00};
  localparam logic [31:0] STPH_ADDR = {STPH_IDX[29:0], 2'b00};
  localparam logic [31:0] STPL_ADDR = {STPL_IDX[29:0], 2'b00};
  localparam logic [31:0] MODE_ADDR = {MODE_IDX[29:0], 2'b00};
  // Field layout
  localparam int HI_W      = 7;   // Address bits 22:16 in bits 6:0
  localparam int LO_W      = 15;  // Address bits 15:1 in bits 15:1
  localparam int CNT_W     = 22;  // Counter holds address bits 22:1
  localparam int SEL_BIT   = 0;
  // Reset values
  localparam logic [6:0]  HI_RST   = 7'h00;
  localparam logic [14:0] LO_RST   = 15'h0000;
  localparam logic        SEL_RST  = 1'b0;
  localparam logic [21:0] CNT_RST  = 22'h000000;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Latency of the slave, address edge to response valid
  localparam int RESP_CYCLES = 2;
endpackage

// File: rtl/vsdma_addr_counter.sv
// Running halfword address counter of the video/scan data mover.
// Assumes one-cycle control pulses synchronous to aclk.
`timescale 1ns/1ps
module vsdma_addr_counter #(
  parameter int W = 22
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         load_en,
  input  wire logic [W-1:0] load_val,
  input  wire logic         alt_en,
  input  wire logic [W-1:0] alt_val,
  input  wire logic         step_en,
  input  wire logic [W-1:0] step_val,
  input  wire logic         adv_en,
  output logic      [W-1:0] count_q
);
  logic [W-1:0] count_d;

  // Software load beats partner events so a commit is never lost
  always_comb begin
    count_d = count_q;
    if (load_en) begin
      count_d = load_val;
    end else if (alt_en) begin
      count_d = alt_val;
    end else if (step_en) begin
      count_d = count_q + step_val;
    end else if (adv_en) begin
      count_d = count_q + W'(1);     // One halfword per transfer
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule // vsdma_addr_counter

// File: rtl/vsdma_axil_slave.sv
// AXI4-Lite slave front end: holds address and data, raises a one-cycle
// access strobe to the register file and returns its answer.
// Assumes one outstanding write and one outstanding read.
`timescale 1ns/1ps
module vsdma_axil_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_fire,
  output logic [31:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic             rd_fire,
  output logic [31:0]      rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);
  logic        aw_q, aw_d, w_q, w_d, ar_q, ar_d;
  logic [31:0] awa_q, awa_d, wd_q, wd_d, ara_q, ara_d;
  logic [3:0]  ws_q, ws_d;
  logic        bv_d, rv_d;
  logic [1:0]  br_d, rr_d;
  logic [31:0] rdat_d;

  // Each channel is ready only while its holding slot is empty
  assign awready = !aw_q;
  assign wready  = !w_q;
  assign arready = !ar_q;
  assign wr_fire = aw_q && w_q && !bvalid;
  assign rd_fire = ar_q && !rvalid;
  assign wr_addr = awa_q;
  assign wr_data = wd_q;
  assign wr_strb = ws_q;
  assign rd_addr = ara_q;

  // Next state of the holding slots and responses
  always_comb begin
    aw_d = aw_q; awa_d = awa_q;
    w_d = w_q; wd_d = wd_q; ws_d = ws_q;
    ar_d = ar_q; ara_d = ara_q;
    bv_d = bvalid; br_d = bresp;
    rv_d = rvalid; rr_d = rresp; rdat_d = rdata;
    if (awvalid && awready) begin
      aw_d = 1'b1; awa_d = awaddr;
    end
    if (wvalid && wready) begin
      w_d = 1'b1; wd_d = wdata; ws_d = wstrb;
    end
    if (arvalid && arready) begin
      ar_d = 1'b1; ara_d = araddr;
    end
    if (bvalid && bready) bv_d = 1'b0;
    if (rvalid && rready) rv_d = 1'b0;
    if (wr_fire) begin
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1;
      br_d = wr_err ? vsdma_pkg::RESP_SLVERR : vsdma_pkg::RESP_OKAY;
    end
    if (rd_fire) begin
      ar_d = 1'b0; rv_d = 1'b1;
      rdat_d = rd_err ? 32'h00000000 : rd_data;
      rr_d = rd_err ? vsdma_pkg::RESP_SLVERR : vsdma_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; awa_q <= 32'h00000000;
      w_q <= 1'b0; wd_q <= 32'h00000000; ws_q <= 4'h0;
      ar_q <= 1'b0; ara_q <= 32'h00000000;
      bvalid <= 1'b0; bresp <= 2'h0;
      rvalid <= 1'b0; rresp <= 2'h0; rdata <= 32'h00000000;
    end else begin
      aw_q <= aw_d; awa_q <= awa_d;
      w_q <= w_d; wd_q <= wd_d; ws_q <= ws_d;
      ar_q <= ar_d; ara_q <= ara_d;
      bvalid <= bv_d; bresp <= br_d;
      rvalid <= rv_d; rresp <= rr_d; rdata <= rdat_d;
    end
  end
endmodule // vsdma_axil_slave

// File: rtl/vsdma_regs.sv
// Address registers of the video/scan data mover behind AXI4-Lite.
// Assumes the capture/scan interface logic pulses its advance, step and
// restart inputs for one aclk cycle each, synchronous to aclk.
`timescale 1ns/1ps
module vsdma_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        xfer_advance,
  input  wire logic        block_step,
  input  wire logic        alt_restart,
  output logic [22:0]      scan_address,
  output logic             capture_or_scan_select
);
  localparam int HW = vsdma_pkg::HI_W;
  localparam int LW = vsdma_pkg::LO_W;
  localparam int CW = vsdma_pkg::CNT_W;

  logic          wr_fire, rd_fire, wr_err, rd_err;
  logic [31:0]   wr_addr, wr_data, rd_addr, rd_data;
  logic [3:0]    wr_strb;
  logic [HW-1:0] hi1_q, hi1_d, hi2_q, hi2_d, sth_q, sth_d;
  logic [LW-1:0] lo2_q, lo2_d, stl_q, stl_d;
  logic          sel_q, sel_d;
  logic          load_en;
  logic [CW-1:0] load_val, count_q;
  logic [15:0]   wr_merge;

  // Byte-lane merge of a write onto a register's present 16-bit image
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0] = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  vsdma_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_fire (wr_fire),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_fire (rd_fire),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  // Present image of the addressed register, used as merge base
  always_comb begin
    wr_merge = 16'h0000;
    if (wr_addr == vsdma_pkg::SAH1_ADDR) begin
      wr_merge = {9'h000, hi1_q};
    end else if (wr_addr == vsdma_pkg::SAL1_ADDR) begin
      wr_merge = {count_q[LW-1:0], 1'b0};
    end else if (wr_addr == vsdma_pkg::SAH2_ADDR) begin
      wr_merge = {9'h000, hi2_q};
    end else if (wr_addr == vsdma_pkg::SAL2_ADDR) begin
      wr_merge = {lo2_q, 1'b0};
    end else if (wr_addr == vsdma_pkg::STPH_ADDR) begin
      wr_merge = {9'h000, sth_q};
    end else if (wr_addr == vsdma_pkg::STPL_ADDR) begin
      wr_merge = {stl_q, 1'b0};
    end else if (wr_addr == vsdma_pkg::MODE_ADDR) begin
      wr_merge = {15'h0000, sel_q};
    end
    wr_merge = merge16(wr_merge, wr_data, wr_strb);
  end

  // Write decode; unmapped addresses answer with an error
  always_comb begin
    hi1_d    = hi1_q;
    hi2_d    = hi2_q;
    lo2_d    = lo2_q;
    sth_d    = sth_q;
    stl_d    = stl_q;
    sel_d    = sel_q;
    load_en  = 1'b0;
    load_val = {hi1_q, wr_merge[LW:1]};
    wr_err   = 1'b0;
    if (wr_fire) begin
      if (wr_addr == vsdma_pkg::SAH1_ADDR) begin
        hi1_d = wr_merge[HW-1:0];                      // Pending only
      end else if (wr_addr == vsdma_pkg::SAL1_ADDR) begin
        load_en = 1'b1;                                // Low write commits
      end else if (wr_addr == vsdma_pkg::SAH2_ADDR) begin
        hi2_d = wr_merge[HW-1:0];
      end else if (wr_addr == vsdma_pkg::SAL2_ADDR) begin
        lo2_d = wr_merge[LW:1];
      end else if (wr_addr == vsdma_pkg::STPH_ADDR) begin
        sth_d = wr_merge[HW-1:0];
      end else if (wr_addr == vsdma_pkg::STPL_ADDR) begin
        stl_d = wr_merge[LW:1];
      end else if (wr_addr == vsdma_pkg::MODE_ADDR) begin
        sel_d = wr_merge[vsdma_pkg::SEL_BIT];
      end else begin
        wr_err = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi1_q <= vsdma_pkg::HI_RST;
      hi2_q <= vsdma_pkg::HI_RST;
      lo2_q <= vsdma_pkg::LO_RST;
      sth_q <= vsdma_pkg::HI_RST;
      stl_q <= vsdma_pkg::LO_RST;
      sel_q <= vsdma_pkg::SEL_RST;
    end else begin
      hi1_q <= hi1_d;
      hi2_q <= hi2_d;
      lo2_q <= lo2_d;
      sth_q <= sth_d;
      stl_q <= stl_d;
      sel_q <= sel_d;
    end
  end

  // Read decode; the first pair mirrors the live counter so software
  // can watch progress, at the cost of a high write reading back only once a low write commits it
  always_comb begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    if (rd_addr == vsdma_pkg::SAH1_ADDR) begin
      rd_data = {25'h0000000, count_q[CW-1:LW]};
    end else if (rd_addr == vsdma_pkg::SAL1_ADDR) begin
      rd_data = {16'h0000, count_q[LW-1:0], 1'b0};
    end else if (rd_addr == vsdma_pkg::SAH2_ADDR) begin
      rd_data = {25'h0000000, hi2_q};
    end else if (rd_addr == vsdma_pkg::SAL2_ADDR) begin
      rd_data = {16'h0000, lo2_q, 1'b0};
    end else if (rd_addr == vsdma_pkg::STPH_ADDR) begin
      rd_data = {25'h0000000, sth_q};
    end else if (rd_addr == vsdma_pkg::STPL_ADDR) begin
      rd_data = {16'h0000, stl_q, 1'b0};
    end else if (rd_addr == vsdma_pkg::MODE_ADDR) begin
      rd_data = {31'h00000000, sel_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Live counter; the step is added as one 22-bit halfword quantity
  vsdma_addr_counter #(
    .W (CW)
  ) u_cnt (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load_en  (load_en),
    .load_val (load_val),
    .alt_en   (alt_restart),
    .alt_val  ({hi2_q, lo2_q}),
    .step_en  (block_step),
    .step_val ({sth_q, stl_q}),
    .adv_en   (xfer_advance),
    .count_q  (count_q)
  );

  // Halfword aligned address to the capture/scan interface
  assign scan_address           = {count_q, 1'b0};
  assign capture_or_scan_select = sel_q;
endmodule // vsdma_regs

// File: verification/vsdma_regs_checker.sv
// Concurrent checks on the ports of the video/scan address registers.
// Assumes it is bound to vsdma_regs and sees only that module's ports.
`timescale 1ns/1ps
module vsdma_regs_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        xfer_advance,
  input wire logic        block_step,
  input wire logic        alt_restart,
  input wire logic [22:0] scan_address
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] rd_addr_d;
  logic [31:0] rd_addr_q;
  logic [31:0] wr_addr_d;
  logic [31:0] wr_addr_q;
  // Remember both addresses so each answer can be tied to its register
  always_comb begin
    rd_addr_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr_q;
    wr_addr_d = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wr_addr_q;
  end
  always_ff @(posedge aclk) begin
    rd_addr_q <= rd_addr_d;
    wr_addr_q <= wr_addr_d;
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_late(v);
    !v ##1 v;
  endsequence
  // Only a low-address-one write loads the counter, visible where bvalid rises;
  // every other write, the pending high half above all, must leave it alone
  sequence s_no_load;
    !($rose(s_axi_bvalid) && wr_addr_q == vsdma_pkg::SAL1_ADDR);
  endsequence
  a_write_latency: assert property (s_wr_take |=> s_late(s_axi_bvalid))
    else $error("write answer not two edges after take");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_late(s_axi_rvalid))
    else $error("read answer not two edges after take");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before taken");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");
  a_addr_halfword: assert property ($rose(s_axi_rvalid) && (rd_addr_q == vsdma_pkg::SAL1_ADDR
    || rd_addr_q == vsdma_pkg::SAL2_ADDR) |-> s_axi_rdata[0] == 1'h0 && scan_address[0] == 1'h0)
    else $error("low address bit 0 not zero");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_advance_one: assert property ((xfer_advance && !block_step && !alt_restart) ##1 s_no_load
    |-> scan_address == $past(scan_address) + 23'h000002)
    else $error("advance did not move one halfword");
  a_idle_hold: assert property ((!xfer_advance && !block_step && !alt_restart) ##1 s_no_load
    |-> $stable(scan_address))
    else $error("counter moved without cause");
  a_high_live: assert property ($rose(s_axi_rvalid) && rd_addr_q == vsdma_pkg::SAH1_ADDR
    && $stable(scan_address) |-> s_axi_rdata == {25'h0000000, scan_address[22:16]})
    else $error("high read is not the counter");
  a_low_live: assert property ($rose(s_axi_rvalid) && rd_addr_q == vsdma_pkg::SAL1_ADDR
    && $stable(scan_address) |-> s_axi_rdata == {16'h0000, scan_address[15:1], 1'h0})
    else $error("low read is not the counter");
endmodule // vsdma_regs_checker

// File: verification/vsdma_regs_tb.sv
// Self-checking bench for the video/scan address registers.
// Assumes the partner model drives the pulses and the checker is bound here.
`timescale 1ns/1ps
module vsdma_regs_tb;
  typedef struct {
    logic [31:0] a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] e;
    logic [1:0]  r;
  } vsdma_row_type;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic xfer_advance, block_step, alt_restart, capture_or_scan_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r2;
  logic [31:0] s_axi_rdata, rd;
  logic [22:0] scan_address;
  int error_cnt = 0, check_count = 0, cycles = 0;
  // Ordinary accesses: write, read back, expected data and response
  vsdma_row_type rows [9] = '{
    '{vsdma_pkg::SAH2_ADDR, 32'hFFFFFFFF, 4'hF, 32'h7F, 2'h0},
    '{vsdma_pkg::SAL2_ADDR, 32'hFFFFFFFF, 4'hF, 32'hFFFE, 2'h0},
    '{vsdma_pkg::STPH_ADDR, 32'h55, 4'hF, 32'h55, 2'h0},
    '{vsdma_pkg::STPL_ADDR, 32'h1235, 4'hF, 32'h1234, 2'h0},
    '{vsdma_pkg::MODE_ADDR, 32'h3, 4'hF, 32'h1, 2'h0},
    '{vsdma_pkg::SAH1_ADDR, 32'h7F, 4'hF, 32'h0, 2'h0},
    '{vsdma_pkg::SAL1_ADDR, 32'h2, 4'hF, 32'h2, 2'h0},
    '{vsdma_pkg::SAH1_ADDR, 32'h1, 4'hF, 32'h7F, 2'h0},
    '{vsdma_pkg::SAH1_ADDR + 32'h4, 32'h1234, 4'hF, 32'h0, 2'h2}};
  vsdma_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xfer_advance, .block_step, .alt_restart,
    .scan_address, .capture_or_scan_select);
  vsdma_scan_partner u_partner (.aclk, .xfer_advance, .block_step, .alt_restart);
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Address and data offered together; each released once taken
  task automatic axi_wr(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);  // Next call raises its strobes at a fresh edge, not this one
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);  // Keeps release and the next request on separate edges
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("scan", 32'h0, {9'h0, scan_address});
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].d, rows[i].s, r2);
      chk("bresp", {30'h0, rows[i].r}, {30'h0, r2});
      axi_rd(rows[i].a, rd, r2);
      chk("rdata", rows[i].e, rd);
      chk("rresp", {30'h0, rows[i].r}, {30'h0, r2});
    end
    chk("scan", 32'h7F0002, {9'h0, scan_address});
    chk("select", 32'h1, {31'h0, capture_or_scan_select});
    axi_wr(vsdma_pkg::MODE_ADDR, 32'h0, 4'hF, r2);
    chk("select", 32'h0, {31'h0, capture_or_scan_select});
    axi_wr(vsdma_pkg::SAL1_ADDR, 32'h10, 4'hF, r2);
    chk("scan", 32'h010010, {9'h0, scan_address});
    u_partner.pulse(3'h1, 3, 2);
    chk("scan", 32'h010016, {9'h0, scan_address});
    axi_rd(vsdma_pkg::SAL1_ADDR, rd, r2);
    chk("low", 32'h16, rd);
    // Step and advance together: the advance is dropped
    u_partner.pulse(3'h3, 1, 0);
    chk("scan", 32'h56124A, {9'h0, scan_address});
    u_partner.pulse(3'h4, 1, 0);
    chk("scan", 32'h7FFFFE, {9'h0, scan_address});
    u_partner.pulse(3'h1, 1, 0);
    chk("scan", 32'h0, {9'h0, scan_address});
    // Low byte only: merges onto the live counter low bits
    axi_wr(vsdma_pkg::SAL1_ADDR, 32'hFF, 4'h1, r2);
    chk("scan", 32'h0100FE, {9'h0, scan_address});
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("scan", 32'h0, {9'h0, scan_address});
    axi_rd(vsdma_pkg::SAH2_ADDR, rd, r2);
    chk("high2", 32'h0, rd);
    end_of_test();
  end
endmodule // vsdma_regs_tb
bind vsdma_regs vsdma_regs_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .xfer_advance, .block_step, .alt_restart, .scan_address);

// File: verification/vsdma_scan_partner.sv
// Model of the capture/scan interface logic that pulses the counter.
// Assumes pulse() is called right after a rising edge of aclk.
`timescale 1ns/1ps
module vsdma_scan_partner (
  input  wire logic aclk,
  output logic      xfer_advance,
  output logic      block_step,
  output logic      alt_restart
);
  // Quiet until commanded, so no stray pulse disturbs register tests
  initial begin
    {alt_restart, block_step, xfer_advance} = 3'h0;
  end
  // One-cycle pulses; a gap models a slow source between transfers
  task automatic pulse(input logic [2:0] which, input int n, input int gap);
    repeat (n) begin
      {alt_restart, block_step, xfer_advance} <= which;
      @(posedge aclk);
      {alt_restart, block_step, xfer_advance} <= 3'h0;
      repeat (gap) @(posedge aclk);
    end
    @(posedge aclk);
  endtask
endmodule // vsdma_scan_partner
